// file: logic/iosr_pkg.sv
/*
  Constants for the I/O space access block: address windows, the
  placement of the block's own registers and their reset values.
  Assumes an 8-bit core with a 16-bit data-space address.
*/
package iosr_pkg;
  // ----------------------------------------------------------------
  // Address windows
  // ----------------------------------------------------------------
  localparam logic [15:0] DS_IO_OFFSET = 16'h0020;
  localparam logic [15:0] DS_IO_LAST = 16'h00FF;
  localparam logic [15:0] DS_EXT_FIRST = 16'h0060;
  localparam logic [7:0] BIT_IO_LAST = 8'h1F;
  localparam logic [7:0] PORT_IO_LAST = 8'h3F;
  // ----------------------------------------------------------------
  // I/O index of the block's own registers
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FLAGS = 8'h1D;
  localparam logic [7:0] IDX_GP0 = 8'h1E;
  localparam logic [7:0] IDX_GP1 = 8'h2A;
  localparam logic [7:0] IDX_GP2 = 8'h2B;
  localparam int GP_COUNT = 3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GP_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
endpackage

// file: logic/iosr_gp_store.sv
/*
  The three general purpose storage registers.
  Assumes one write at most per cycle, already decoded by the caller.
*/
module iosr_gp_store
  import iosr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Write request
  input wire logic wr,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] wmask,
  // Stored values
  output logic [GP_COUNT-1:0][7:0] store_q
);
  typedef struct packed {
    logic [GP_COUNT-1:0][7:0] store;
  } iosr_gp_state_type;

  iosr_gp_state_type s_q;
  iosr_gp_state_type s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < GP_COUNT; i++) begin
      // Masked write: a bit operation touches only its own bit
      if (wr && (sel == 2'(i))) begin
        s_d.store[i] = (s_q.store[i] & ~wmask) | (wdata & wmask);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '{store: {GP_COUNT{GP_RESET}}};
    end else begin
      s_q <= s_d;
    end
  end

  assign store_q = s_q.store;
endmodule // iosr_gp_store

// file: logic/iosr_io_space.sv
/*
  I/O space access unit: decodes the core's data-space, port-mapped
  and single-bit accesses into one I/O index, serves the storage and
  flag registers itself and forwards the rest to the peripherals.
  Assumes the core issues at most one access per cycle and that
  peripherals answer per_rdata in the cycle per_rd_q is high.
*/
module iosr_io_space
  import iosr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data-space load and store
  input wire logic [15:0] ds_addr,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic [7:0] ds_wdata,
  // Port-mapped read and write
  input wire logic [5:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  // Single-bit operations
  input wire logic [4:0] bit_addr,
  input wire logic [2:0] bit_num,
  input wire logic bit_set,
  input wire logic bit_clr,
  input wire logic bit_skip_set,
  input wire logic bit_skip_clr,
  // Answer to the core
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic skip_q,
  // Peripheral side
  output logic [7:0] per_idx_q,
  output logic per_rd_q,
  output logic per_wr_q,
  output logic [7:0] per_wdata_q,
  output logic [7:0] per_wmask_q,
  input wire logic [7:0] per_rdata,
  // Status flags owned by this block
  input wire logic [7:0] flag_evt,
  output logic [7:0] flags_q
);
  typedef struct packed {
    logic [7:0] per_idx;
    logic per_rd;
    logic per_wr;
    logic [7:0] per_wdata;
    logic [7:0] per_wmask;
    logic p_rd;
    logic p_local;
    logic [7:0] p_lval;
    logic p_test;
    logic p_pol;
    logic [2:0] p_bit;
    logic [7:0] rdata;
    logic rvalid;
    logic skip;
    logic [7:0] flags;
  } iosr_state_type;

  iosr_state_type s_q;
  iosr_state_type s_d;
  logic [GP_COUNT-1:0][7:0] gp_q;
  logic gp_wr;
  logic [1:0] gp_sel;
  logic acc_rd;
  logic acc_wr;
  logic acc_test;
  logic acc_pol;
  logic [7:0] acc_idx;
  logic [7:0] acc_wdata;
  logic [7:0] acc_mask;
  logic [7:0] lval;
  logic is_local;
  logic [15:0] ds_rel;
  logic [7:0] rval;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // Data space wins over port and bit requests if the core ever
  // overlaps them; it never should.
  always_comb begin
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_test = 1'b0;
    acc_pol = 1'b0;
    acc_idx = 8'h00;
    acc_wdata = 8'h00;
    acc_mask = 8'hFF;
    // Wraps below the offset; the window test keeps that harmless
    ds_rel = ds_addr - DS_IO_OFFSET;
    if (ds_rd || ds_wr) begin
      // Below the offset lie the working registers, not ours
      if ((ds_addr >= DS_IO_OFFSET) && (ds_addr <= DS_IO_LAST)) begin
        acc_rd = ds_rd;
        acc_wr = ds_wr;
        acc_idx = ds_rel[7:0];
        acc_wdata = ds_wdata;
      end
    end else if (io_rd || io_wr) begin
      // Six address bits cannot reach the extended region
      acc_rd = io_rd;
      acc_wr = io_wr;
      acc_idx = {2'b00, io_addr};
      acc_wdata = io_wdata;
    end else if (bit_set || bit_clr || bit_skip_set || bit_skip_clr) begin
      acc_idx = {3'b000, bit_addr};
      acc_mask = 8'h01 << bit_num;
      acc_wdata = bit_set ? acc_mask : 8'h00;
      acc_wr = bit_set || bit_clr;
      acc_rd = bit_skip_set || bit_skip_clr;
      acc_test = acc_rd;
      acc_pol = bit_skip_set;
    end
  end

  // ----------------------------------------------------------------
  // Local registers
  // ----------------------------------------------------------------
  always_comb begin
    is_local = 1'b1;
    gp_sel = 2'd0;
    lval = 8'h00;
    case (acc_idx)
      IDX_GP0: begin
        gp_sel = 2'd0;
        lval = gp_q[0];
      end
      IDX_GP1: begin
        gp_sel = 2'd1;
        lval = gp_q[1];
      end
      IDX_GP2: begin
        gp_sel = 2'd2;
        lval = gp_q[2];
      end
      IDX_FLAGS: lval = s_q.flags;
      default: is_local = 1'b0;
    endcase
  end

  // The flag register is local but never reaches the storage write port
  assign gp_wr = acc_wr && is_local && (acc_idx != IDX_FLAGS);

  iosr_gp_store u_gp (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr(gp_wr),
    .sel(gp_sel),
    .wdata(acc_wdata),
    .wmask(acc_mask),
    .store_q(gp_q)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Local read data is captured at the taking edge, so a write in the
  // same cycle shows only on a later read
  assign rval = s_q.p_local ? s_q.p_lval : per_rdata;

  always_comb begin
    s_d = s_q;
    // Forward non-local accesses with the lane mask so a peripheral
    // can keep its other bits, including one-to-clear flags
    s_d.per_rd = acc_rd && !is_local;
    s_d.per_wr = acc_wr && !is_local;
    s_d.per_idx = acc_idx;
    s_d.per_wdata = acc_wdata;
    s_d.per_wmask = acc_mask;
    s_d.p_rd = acc_rd;
    s_d.p_local = is_local;
    s_d.p_lval = lval;
    s_d.p_test = acc_test;
    s_d.p_pol = acc_pol;
    s_d.p_bit = bit_num;
    s_d.rvalid = s_q.p_rd;
    s_d.rdata = s_q.p_rd ? rval : s_q.rdata;
    // Skip uses the same captured byte as the read answer
    s_d.skip = s_q.p_test && (rval[s_q.p_bit] == s_q.p_pol);
    // A new event wins over a clear in the same cycle
    s_d.flags = s_q.flags | flag_evt;
    if (acc_wr && (acc_idx == IDX_FLAGS)) begin
      s_d.flags = (s_q.flags & ~(acc_wdata & acc_mask)) | flag_evt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      // Flags reset apart so their reset value may differ from the rest
      s_q.flags <= FLAG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_q = s_q.rdata;
  assign rvalid_q = s_q.rvalid;
  assign skip_q = s_q.skip;
  assign per_idx_q = s_q.per_idx;
  assign per_rd_q = s_q.per_rd;
  assign per_wr_q = s_q.per_wr;
  assign per_wdata_q = s_q.per_wdata;
  assign per_wmask_q = s_q.per_wmask;
  assign flags_q = s_q.flags;
endmodule // iosr_io_space

// file: verif/iosr_io_space_asserts.sv
/* Checker for the I/O space access unit.
   Assumes one core request per cycle. */
module iosr_io_space_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core side
  input wire logic [15:0] ds_addr,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic [7:0] ds_wdata,
  input wire logic [5:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [4:0] bit_addr,
  input wire logic [2:0] bit_num,
  input wire logic bit_set,
  input wire logic bit_skip_set,
  input wire logic rvalid_q,
  input wire logic skip_q,
  // Peripheral side and flags
  input wire logic [7:0] per_idx_q,
  input wire logic per_rd_q,
  input wire logic per_wr_q,
  input wire logic [7:0] per_wmask_q,
  input wire logic [7:0] flag_evt,
  input wire logic [7:0] flags_q
);
  timeunit 1ns;
  timeprecision 1ns;
  wire q = !(ds_rd | ds_wr | io_rd | io_wr);
  wire nds = !(ds_rd | ds_wr);
  wire win = ds_addr inside {[16'h0020:16'h00FF]};
  wire ext = ds_addr inside {[16'h0060:16'h00FF]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_ds_read: assert property (ds_rd && win |-> ##2 rvalid_q)
    else $error("load gave no answer");
  chk_ds_drop: assert property (ds_rd && !win && !io_rd && !bit_skip_set
    |-> ##2 !rvalid_q) else $error("load outside window answered");
  chk_ds_index: assert property ((ds_rd | ds_wr) && ext |=>
    per_idx_q == $past(ds_addr[7:0]) - 8'h20) else $error("bad index");
  chk_ext_write: assert property (ds_wr && ext |=> per_wr_q &&
    per_wmask_q == 8'hFF) else $error("extended store lost");
  chk_io_index: assert property (io_rd && nds && io_addr < 6'h1D |=>
    per_rd_q && per_idx_q == {2'b0, $past(io_addr)}) else $error("io idx");
  chk_bit_mask: assert property (bit_set && q && bit_addr < 5'h1D |=>
    per_wmask_q == 8'h01 << $past(bit_num)) else $error("bit mask");
  chk_skip_ans: assert property (bit_skip_set && q |-> ##2 rvalid_q)
    else $error("bit test gave no answer");
  chk_flag_clear: assert property (ds_wr && ds_addr == 16'h003D &&
    flag_evt == 0 |=> flags_q == ($past(flags_q) & ~$past(ds_wdata)))
    else $error("flag clear wrong");
  cover property (skip_q);
  cover property (per_rd_q);
  cover property (flags_q == 8'h0A);
endmodule // iosr_io_space_asserts
bind iosr_io_space iosr_io_space_asserts chk_u (
  .clk_sys(clk_sys), .rst(rst), .ds_addr(ds_addr), .ds_rd(ds_rd),
  .ds_wr(ds_wr), .ds_wdata(ds_wdata), .io_addr(io_addr), .io_rd(io_rd),
  .io_wr(io_wr), .bit_addr(bit_addr), .bit_num(bit_num),
  .bit_set(bit_set), .bit_skip_set(bit_skip_set), .rvalid_q(rvalid_q),
  .skip_q(skip_q), .per_idx_q(per_idx_q), .per_rd_q(per_rd_q),
  .per_wr_q(per_wr_q), .per_wmask_q(per_wmask_q), .flag_evt(flag_evt),
  .flags_q(flags_q)
);

// file: verif/iosr_periph_model.sv
/* Peripheral stand-in behind the forwarded path.
   Assumes read data is sampled while per_rd_q is high. */
module iosr_periph_model (
  // Forwarded access
  input wire logic clk_sys,
  input wire logic [7:0] per_idx_q,
  input wire logic per_rd_q,
  input wire logic per_wr_q,
  input wire logic [7:0] per_wdata_q,
  input wire logic [7:0] per_wmask_q,
  // Read data
  output logic [7:0] per_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [256];
  initial for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'hA5;
  // Outside a read the bus shows the inverse, never stale data
  assign per_rdata = per_rd_q ? m[per_idx_q] : ~m[per_idx_q];
  always @(posedge clk_sys)
    if (per_wr_q)
      m[per_idx_q] <= m[per_idx_q] & ~per_wmask_q | per_wdata_q & per_wmask_q;
endmodule // iosr_periph_model

// file: verif/test_io_space_register_access.sv
/* Bench for the I/O space access unit.
   Acts as the core; a model sits behind the forwarded path. */
module test_io_space_register_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0;
  logic rst = 1;
  logic [15:0] ds_addr = 0;
  logic [7:0] st = 0, ds_wdata = 0, io_wdata = 0, flag_evt = 0, v;
  logic [5:0] io_addr = 0;
  logic [4:0] bit_addr = 0;
  logic [2:0] bit_num = 0;
  logic ds_rd, ds_wr, io_rd, io_wr, bit_set, bit_clr, bit_skip_set;
  logic bit_skip_clr, rvalid_q, skip_q, per_rd_q, per_wr_q, sk;
  logic [7:0] rdata_q, per_idx_q, per_wdata_q, per_wmask_q;
  logic [7:0] per_rdata, flags_q;
  int errors = 0, n_checks = 0, cyc = 0;
  assign {ds_rd, ds_wr, io_rd, io_wr, bit_set, bit_clr} = st[7:2];
  assign {bit_skip_set, bit_skip_clr} = st[1:0];
  iosr_io_space dut_u (
    .clk_sys(clk_sys), .rst(rst), .ds_addr(ds_addr), .ds_rd(ds_rd),
    .ds_wr(ds_wr), .ds_wdata(ds_wdata), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .bit_addr(bit_addr),
    .bit_num(bit_num), .bit_set(bit_set), .bit_clr(bit_clr),
    .bit_skip_set(bit_skip_set), .bit_skip_clr(bit_skip_clr),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .skip_q(skip_q),
    .per_idx_q(per_idx_q), .per_rd_q(per_rd_q), .per_wr_q(per_wr_q),
    .per_wdata_q(per_wdata_q), .per_wmask_q(per_wmask_q),
    .per_rdata(per_rdata), .flag_evt(flag_evt), .flags_q(flags_q)
  );
  iosr_periph_model per_u (
    .clk_sys(clk_sys), .per_idx_q(per_idx_q), .per_rd_q(per_rd_q),
    .per_wr_q(per_wr_q), .per_wdata_q(per_wdata_q),
    .per_wmask_q(per_wmask_q), .per_rdata(per_rdata)
  );
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (++cyc == 3000) begin
      errors++;
      summarize();
    end
  task automatic summarize;
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Kind: 0 load 1 store 2 in 3 out 4 set 5 clear 6/7 skip set/clear
  task automatic go(int k, logic [15:0] a, logic [7:0] d);
    @(posedge clk_sys);
    ds_addr <= a;
    io_addr <= a[5:0];
    bit_addr <= a[4:0];
    bit_num <= d[2:0];
    ds_wdata <= d;
    io_wdata <= d;
    st <= 8'h80 >> k;
    @(posedge clk_sys);
    st <= 0;
  endtask
  task automatic rd(int k, logic [15:0] a, logic [7:0] d);
    go(k, a, d);
    @(posedge clk_sys);
    #1;
    chk("rvalid_q", 1, rvalid_q);
    v = rdata_q;
    sk = skip_q;
  endtask
  task automatic t_reset;
    logic [15:0] a[4] = '{16'h003E, 16'h004A, 16'h004B, 16'h003D};
    foreach (a[i]) begin
      rd(0, a[i], 0);
      chk("reset value", 8'h00, v);
    end
  endtask
  task automatic t_store;
    logic [15:0] a[3] = '{16'h003E, 16'h004A, 16'h004B};
    foreach (a[i]) go(1, a[i], 8'hC3 ^ 8'(i));
    foreach (a[i]) begin
      rd(0, a[i], 0);
      chk("store", 8'hC3 ^ 8'(i), v);
    end
    rd(2, 16'h001E, 0);
    chk("in store0", 8'hC3, v);
    go(3, 16'h002A, 8'h77);
    rd(0, 16'h004A, 0);
    chk("out store1", 8'h77, v);
  endtask
  task automatic t_bits;
    go(1, 16'h003E, 8'hA0);
    go(4, 16'h001E, 8'h03);
    rd(0, 16'h003E, 0);
    chk("bit set", 8'hA8, v);
    rd(6, 16'h001E, 8'h03);
    chk("skip set", 1, sk);
    rd(7, 16'h001E, 8'h03);
    chk("skip clear", 0, sk);
    go(5, 16'h001E, 8'h03);
    rd(0, 16'h003E, 0);
    chk("bit clear", 8'hA0, v);
    rd(7, 16'h001E, 8'h03);
    chk("skip clear hit", 1, sk);
  endtask
  task automatic t_flags;
    @(posedge clk_sys);
    flag_evt <= 8'h0F;
    @(posedge clk_sys);
    flag_evt <= 0;
    go(1, 16'h003D, 8'h05);
    rd(0, 16'h003D, 0);
    chk("flags", 8'h0A, v);
    go(4, 16'h001D, 8'h01);
    rd(0, 16'h003D, 0);
    chk("flags bit", 8'h08, v);
  endtask
  task automatic t_periph;
    rd(2, 16'h0005, 0);
    chk("in periph", 8'hA0, v);
    rd(0, 16'h0025, 0);
    chk("load periph", 8'hA0, v);
    go(4, 16'h0005, 8'h02);
    rd(2, 16'h0005, 0);
    chk("bit set periph", 8'hA4, v);
    rd(6, 16'h0005, 8'h02);
    chk("skip periph", 1, sk);
    go(1, 16'h0080, 8'h5A);
    rd(0, 16'h0080, 0);
    chk("ext", 8'h5A, v);
    go(0, 16'h0100, 0);
    @(posedge clk_sys);
    #1;
    chk("rvalid_q", 0, rvalid_q);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    t_reset();
    t_store();
    t_bits();
    t_flags();
    t_periph();
    summarize();
  end
endmodule // test_io_space_register_access
